// ==== hdl/ppp_pkg.sv ====
// Constants, types and decode functions shared by the parallel port design.
`default_nettype none
package ppp_pkg;
    // Register offsets on the board; the device decodes only the two low bits.
    localparam logic [3:0] PORT_A_DATA_OFF = 4'h4;
    localparam logic [3:0] PORT_B_DATA_OFF = 4'h5;
    localparam logic [3:0] PORT_C_DATA_OFF = 4'h6;
    localparam logic [3:0] CONTROL_WORD_OFF = 4'h7;
    localparam logic [3:0] SECOND_PORT_A_DATA_OFF = 4'h8;
    localparam logic [3:0] SECOND_PORT_B_DATA_OFF = 4'h9;
    localparam logic [3:0] SECOND_PORT_C_DATA_OFF = 4'hA;
    localparam logic [3:0] SECOND_CONTROL_WORD_OFF = 4'hB;

    // Local selects as seen on the two address pins.
    localparam logic [1:0] SEL_PA = 2'h0;
    localparam logic [1:0] SEL_PB = 2'h1;
    localparam logic [1:0] SEL_PC = 2'h2;
    localparam logic [1:0] SEL_CW = 2'h3;

    // Control word fields.
    localparam int CW_MODESET = 7;
    localparam int CW_GA_MODE_HI = 6;
    localparam int CW_GA_MODE_LO = 5;
    localparam int CW_PA_IN = 4;
    localparam int CW_PCU_IN = 3;
    localparam int CW_GB_MODE = 2;
    localparam int CW_PB_IN = 1;
    localparam int CW_PCL_IN = 0;
    localparam int BSR_SEL_HI = 3;
    localparam int BSR_SEL_LO = 1;
    localparam int BSR_VAL = 0;

    // Mode 0 with every port as input.
    localparam logic [7:0] CTRL_RESET = 8'h9B;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] CW_READ_VALUE = 8'h00;

    // Port C handshake positions.
    localparam int PC_INTERRUPT_REQUEST_B = 0;
    localparam int PC_BUF_B = 1;
    localparam int PC_STB_B = 2;
    localparam int PC_INTERRUPT_REQUEST_A = 3;
    localparam int PC_STB_A = 4;
    localparam int PC_IBF_A = 5;
    localparam int PC_ACK_A = 6;
    localparam int PC_OBF_A = 7;

    typedef enum logic [1:0] {
        PPP_MODE0 = 2'b00,
        PPP_MODE1 = 2'b01,
        PPP_MODE2 = 2'b10
    } ppp_mode_t;

    // Group A mode: the upper field bit selects mode 2 whatever the lower bit says.
    function automatic ppp_mode_t ga_mode(input logic [7:0] cw);
        if (cw[CW_GA_MODE_HI]) begin
            return PPP_MODE2;
        end
        return cw[CW_GA_MODE_LO] ? PPP_MODE1 : PPP_MODE0;
    endfunction

    // Group B can only ever run in mode 0 or mode 1.
    function automatic ppp_mode_t gb_mode(input logic [7:0] cw);
        return cw[CW_GB_MODE] ? PPP_MODE1 : PPP_MODE0;
    endfunction
endpackage
`default_nettype wire

// ==== hdl/ppp_hs_if.sv ====
// Handshake channel signals between the port controller and one strobed channel.
`default_nettype none
interface ppp_hs_if;
    logic clr;
    logic in_en;
    logic out_en;
    logic inte_in;
    logic inte_out;
    logic stb_fall;
    logic ack_fall;
    logic rd_evt;
    logic wr_evt;
    logic [7:0] pin_d;
    logic [7:0] in_data;
    logic input_buffer_full;
    logic output_buffer_full;
    logic interrupt_request;
    modport ctrl (output clr, in_en, out_en, inte_in, inte_out, stb_fall, ack_fall,
                  rd_evt, wr_evt, pin_d, input in_data, input_buffer_full, output_buffer_full, interrupt_request);
    modport chan (input clr, in_en, out_en, inte_in, inte_out, stb_fall, ack_fall,
                  rd_evt, wr_evt, pin_d, output in_data, input_buffer_full, output_buffer_full, interrupt_request);
endinterface
`default_nettype wire

// ==== hdl/ppp_edge.sv ====
// Registered edge detector for a group of sampled levels.
`default_nettype none
module ppp_edge #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] lvl_i,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] prev_r;

    // The idle level at reset keeps a line that starts inactive from faking an edge.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r <= IDLE;
        end else begin
            prev_r <= lvl_i;
        end
    end

    // Edges are one-cycle pulses in the cycle the new level is first seen.
    assign rise_o = lvl_i & ~prev_r;
    assign fall_o = ~lvl_i & prev_r;
endmodule
`default_nettype wire

// ==== hdl/ppp_hs_chan.sv ====
// One strobed channel: input latch with buffer-full flag and output buffer flag.
`default_nettype none
module ppp_hs_chan (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    ppp_hs_if.chan hs
);
    logic [7:0] in_data_r;
    logic ibf_r;
    logic obf_r;
    logic interrupt_request_in_r;
    logic interrupt_request_out_r;
    logic take;

    assign take = hs.in_en & hs.stb_fall;

    // Input data is captured on the strobe's falling edge only.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_data_r <= ppp_pkg::LATCH_RESET;
        end else if (hs.clr) begin
            in_data_r <= ppp_pkg::LATCH_RESET;
        end else if (take) begin
            in_data_r <= hs.pin_d;
        end
    end

    // Buffer full and its request; a strobe in the read-end cycle still wins.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ibf_r <= 1'b0;
            interrupt_request_in_r <= 1'b0;
        end else if (hs.clr) begin
            ibf_r <= 1'b0;
            interrupt_request_in_r <= 1'b0;
        end else if (take) begin
            ibf_r <= 1'b1;
            interrupt_request_in_r <= 1'b1;
        end else if (hs.rd_evt) begin
            ibf_r <= 1'b0;
            interrupt_request_in_r <= 1'b0;
        end
    end

    // Output buffer flag; a write in the acknowledge cycle leaves the buffer full.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            obf_r <= 1'b0;
        end else if (hs.clr) begin
            obf_r <= 1'b0;
        end else if (hs.out_en & hs.wr_evt) begin
            obf_r <= 1'b1;
        end else if (hs.out_en & hs.ack_fall) begin
            obf_r <= 1'b0;
        end
    end

    // Output side request: set by the acknowledge, dropped by the next write.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_request_out_r <= 1'b0;
        end else if (hs.clr) begin
            interrupt_request_out_r <= 1'b0;
        end else if (hs.out_en & hs.ack_fall) begin
            interrupt_request_out_r <= 1'b1;
        end else if (hs.wr_evt) begin
            interrupt_request_out_r <= 1'b0;
        end
    end

    assign hs.in_data = in_data_r;
    assign hs.input_buffer_full = ibf_r;
    assign hs.output_buffer_full = obf_r;
    // Enables are read live, so software can mask a pending request without losing it.
    assign hs.interrupt_request = (hs.in_en & hs.inte_in & interrupt_request_in_r) |
                     (hs.out_en & hs.inte_out & interrupt_request_out_r);
endmodule
`default_nettype wire

// ==== hdl/ppp_top.sv ====
// Programmable parallel port: three 8-bit ports with mode 0, 1 and 2 operation.
`default_nettype none
module ppp_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_i,
    output logic [7:0] pb_o,
    output logic [7:0] pb_oe_o,
    input wire logic [7:0] pc_i,
    output logic [7:0] pc_o,
    output logic [7:0] pc_oe_o
);
    logic [7:0] ctrl_r;
    logic [7:0] pa_latch_r;
    logic [7:0] pb_latch_r;
    logic [7:0] pc_latch_r;
    logic [7:0] rdata_r;
    logic [1:0] addr_r;
    ppp_pkg::ppp_mode_t mode_a;
    ppp_pkg::ppp_mode_t mode_b;
    logic pa_in;
    logic pb_in;
    logic wr_act;
    logic rd_act;
    logic [4:0] rise;
    logic [4:0] fall;
    logic wr_evt;
    logic rd_end;
    logic wr_pa;
    logic wr_pb;
    logic wr_pc;
    logic mode_set;
    logic bit_set;
    logic [7:0] hs_out;
    logic [7:0] hs_in;
    logic [7:0] hs_val;
    logic [7:0] io_mask;
    logic [7:0] io_dir_out;
    logic [7:0] pa_rd;
    logic [7:0] pb_rd;
    logic [7:0] pc_rd;
    logic [7:0] rd_mux;

    // One handshake channel per strobed port. Channel B has no mode 2, so its
    // bidirectional paths are simply never enabled by the decode below.
    ppp_hs_if hs_a ();
    ppp_hs_if hs_b ();

    // Mode and direction decode from the stored mode word. The decode is
    // combinational from one register, so a new mode word takes effect on
    // the pins in the cycle after the write that carries it.
    assign mode_a = ppp_pkg::ga_mode(ctrl_r);
    assign mode_b = ppp_pkg::gb_mode(ctrl_r);
    assign pa_in = ctrl_r[ppp_pkg::CW_PA_IN];
    assign pb_in = ctrl_r[ppp_pkg::CW_PB_IN];
    assign io_dir_out = {{4{~ctrl_r[ppp_pkg::CW_PCU_IN]}},
                         {4{~ctrl_r[ppp_pkg::CW_PCL_IN]}}};

    // Bus cycle qualifiers; a high chip select hides both strobes.
    // The bus pins are taken as synchronous, so no synchroniser sits here;
    // a master on another clock must resynchronise them first.
    assign wr_act = ~cs_n_i & ~wr_n_i;
    assign rd_act = ~cs_n_i & ~rd_n_i;

    // Edges of the bus strobes and the three peripheral handshake inputs.
    // The idle value has the peripheral lines high and the bus strobes
    // inactive, so the first cycle after reset shows no edge at all.
    ppp_edge #(
        .W(5),
        .IDLE(5'h1C)
    ) u_edge (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .lvl_i({pc_i[ppp_pkg::PC_ACK_A], pc_i[ppp_pkg::PC_STB_A],
                pc_i[ppp_pkg::PC_STB_B], rd_act, wr_act}),
        .rise_o(rise),
        .fall_o(fall)
    );

    // Writes act in the first cycle of the strobe, so data must be valid then.
    // Holding the strobe low for many cycles still counts as one write.
    assign wr_evt = rise[0];
    // Read side effects wait for the end of the read, so the data is seen first.
    // A read therefore clears its flag only after the byte has been taken.
    assign rd_end = fall[1];
    assign wr_pa = wr_evt & (addr_i == ppp_pkg::SEL_PA);
    assign wr_pb = wr_evt & (addr_i == ppp_pkg::SEL_PB);
    assign wr_pc = wr_evt & (addr_i == ppp_pkg::SEL_PC);
    assign mode_set = wr_evt & (addr_i == ppp_pkg::SEL_CW) &
                      data_i[ppp_pkg::CW_MODESET];
    assign bit_set = wr_evt & (addr_i == ppp_pkg::SEL_CW) &
                     ~data_i[ppp_pkg::CW_MODESET];

    // Address of the read in progress, held for its end-of-read effects.
    // The read mux itself uses the live address, so only side effects need it.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_r <= ppp_pkg::SEL_PA;
        end else if (rd_act) begin
            addr_r <= addr_i;
        end
    end

    // Mode word; reset selects mode 0 with every port as input.
    // Bit set/reset words never reach this register; they only touch port C.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= ppp_pkg::CTRL_RESET;
        end else if (mode_set) begin
            ctrl_r <= data_i;
        end
    end

    // Port A and B output latches hold until the next write or mode change.
    // Clearing on a mode change keeps stale data off pins that turn into outputs.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pa_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (mode_set) begin
            pa_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (wr_pa) begin
            pa_latch_r <= data_i;
        end
    end

    // Port B latch follows the same rules as port A.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (mode_set) begin
            pb_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (wr_pb) begin
            pb_latch_r <= data_i;
        end
    end

    // Port C latch; handshake input positions hold the request enables, so a
    // plain data write only reaches the lines left as ordinary I/O.
    // Bit set/reset reaches every line, handshake positions included.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (mode_set) begin
            pc_latch_r <= ppp_pkg::LATCH_RESET;
        end else if (bit_set) begin
            pc_latch_r[data_i[ppp_pkg::BSR_SEL_HI:ppp_pkg::BSR_SEL_LO]] <=
                data_i[ppp_pkg::BSR_VAL];
        end else if (wr_pc) begin
            pc_latch_r <= (pc_latch_r & ~io_mask) | (data_i & io_mask);
        end
    end

    // Channel A serves mode 1 in either direction and both directions in mode 2.
    // Its request enables live in the port C latch at the strobe and ack positions.
    assign hs_a.clr = mode_set;
    assign hs_a.in_en = (mode_a == ppp_pkg::PPP_MODE2) |
                        ((mode_a == ppp_pkg::PPP_MODE1) & pa_in);
    assign hs_a.out_en = (mode_a == ppp_pkg::PPP_MODE2) |
                         ((mode_a == ppp_pkg::PPP_MODE1) & ~pa_in);
    assign hs_a.inte_in = pc_latch_r[ppp_pkg::PC_STB_A];
    assign hs_a.inte_out = pc_latch_r[ppp_pkg::PC_ACK_A];
    assign hs_a.stb_fall = fall[3];
    assign hs_a.ack_fall = fall[4];
    assign hs_a.rd_evt = rd_end & (addr_r == ppp_pkg::SEL_PA);
    assign hs_a.wr_evt = wr_pa;
    assign hs_a.pin_d = pa_i;

    // Channel B shares one handshake input for strobe or acknowledge.
    // Input and output never run together here, so sharing the line is safe.
    assign hs_b.clr = mode_set;
    assign hs_b.in_en = (mode_b == ppp_pkg::PPP_MODE1) & pb_in;
    assign hs_b.out_en = (mode_b == ppp_pkg::PPP_MODE1) & ~pb_in;
    assign hs_b.inte_in = pc_latch_r[ppp_pkg::PC_STB_B];
    assign hs_b.inte_out = pc_latch_r[ppp_pkg::PC_STB_B];
    assign hs_b.stb_fall = fall[2];
    assign hs_b.ack_fall = fall[2];
    assign hs_b.rd_evt = rd_end & (addr_r == ppp_pkg::SEL_PB);
    assign hs_b.wr_evt = wr_pb;
    assign hs_b.pin_d = pb_i;

    // The channels keep the flags; this module only routes their pins.
    ppp_hs_chan u_chan_a (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .hs(hs_a.chan)
    );

    ppp_hs_chan u_chan_b (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .hs(hs_b.chan)
    );

    // Port C line roles: handshake outputs, handshake inputs, or plain I/O.
    // The two channels claim disjoint lines, so no branch undoes another.
    always_comb begin
        hs_out = 8'h00;
        hs_in = 8'h00;
        hs_val = 8'h00;
        if (hs_a.in_en | hs_a.out_en) begin
            hs_out[ppp_pkg::PC_INTERRUPT_REQUEST_A] = 1'b1;
            hs_val[ppp_pkg::PC_INTERRUPT_REQUEST_A] = hs_a.interrupt_request;
        end
        if (hs_a.in_en) begin
            hs_out[ppp_pkg::PC_IBF_A] = 1'b1;
            hs_val[ppp_pkg::PC_IBF_A] = hs_a.input_buffer_full;
            hs_in[ppp_pkg::PC_STB_A] = 1'b1;
        end
        // The output-full pin is active low, hence the inversion.
        if (hs_a.out_en) begin
            hs_out[ppp_pkg::PC_OBF_A] = 1'b1;
            hs_val[ppp_pkg::PC_OBF_A] = ~hs_a.output_buffer_full;
            hs_in[ppp_pkg::PC_ACK_A] = 1'b1;
        end
        // Port B uses one line for buffer full in either direction.
        if (hs_b.in_en | hs_b.out_en) begin
            hs_out[ppp_pkg::PC_INTERRUPT_REQUEST_B] = 1'b1;
            hs_val[ppp_pkg::PC_INTERRUPT_REQUEST_B] = hs_b.interrupt_request;
            hs_out[ppp_pkg::PC_BUF_B] = 1'b1;
            hs_val[ppp_pkg::PC_BUF_B] = hs_b.in_en ? hs_b.input_buffer_full : ~hs_b.output_buffer_full;
            hs_in[ppp_pkg::PC_STB_B] = 1'b1;
        end
    end

    // Plain I/O lines are whatever no handshake role has claimed.
    assign io_mask = ~(hs_out | hs_in);

    // Pin drive; mode 2 turns port A round only while the acknowledge is low.
    // The output latch stays loaded while the pins float, so no byte is lost.
    assign pa_o = pa_latch_r;
    assign pa_oe_o = (mode_a == ppp_pkg::PPP_MODE2) ? {8{~pc_i[ppp_pkg::PC_ACK_A]}} :
                     {8{~pa_in}};
    assign pb_o = pb_latch_r;
    assign pb_oe_o = {8{~pb_in}};
    assign pc_o = (hs_out & hs_val) | (~hs_out & pc_latch_r);
    assign pc_oe_o = hs_out | (io_mask & io_dir_out);

    // Read values: mode 0 inputs pass straight through, strobed inputs use the latch.
    // Port C reads mix status, request enables and plain lines bit by bit.
    assign pa_rd = hs_a.in_en ? hs_a.in_data : (pa_in ? pa_i : pa_latch_r);
    assign pb_rd = hs_b.in_en ? hs_b.in_data : (pb_in ? pb_i : pb_latch_r);
    assign pc_rd = (hs_out & hs_val) | (hs_in & pc_latch_r) |
                   (io_mask & ((io_dir_out & pc_latch_r) | (~io_dir_out & pc_i)));

    // Read source by address; the control word reads back as zero.
    always_comb begin
        case (addr_i)
            ppp_pkg::SEL_PA: rd_mux = pa_rd;
            ppp_pkg::SEL_PB: rd_mux = pb_rd;
            ppp_pkg::SEL_PC: rd_mux = pc_rd;
            default: rd_mux = ppp_pkg::CW_READ_VALUE;
        endcase
    end

    // Read data is registered, so it is valid from the second cycle of a read.
    // The register also keeps the last byte on data_o once the read ends.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= ppp_pkg::LATCH_RESET;
        end else if (rd_act) begin
            rdata_r <= rd_mux;
        end
    end

    // Data out comes straight from the read register.
    assign data_o = rdata_r;
    // The control word cannot be read, so the bus is left undriven there.
    assign data_oe_o = rd_act & (addr_i != ppp_pkg::SEL_CW);
endmodule
`default_nettype wire

// ==== verification/ppp_asserts.sv ====
// Concurrent checks on the parallel port's bus and pin signals.
`default_nettype none
module ppp_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_o,
    input wire logic [7:0] pa_o,
    input wire logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_oe_o,
    input wire logic [7:0] pc_i,
    input wire logic [7:0] pc_o,
    input wire logic [7:0] pc_oe_o
);
    logic wr_lvl;
    logic wr_go;
    logic in_a;
    logic out_a;
    logic wr_prev_r;
    logic seen_r;
    logic [7:0] cw_r;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // A held write strobe counts once, on its first cycle.
    assign wr_lvl = !cs_n_i && !wr_n_i;
    assign wr_go = wr_lvl && !wr_prev_r;
    assign in_a = cw_r[6] || cw_r[6:4] == 3'b011;
    assign out_a = cw_r[6] || cw_r[6:4] == 3'b010;
    // Shadow of the mode word; bit set/reset words leave it untouched.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_prev_r <= 1'b0;
            seen_r <= 1'b0;
            cw_r <= ppp_pkg::CTRL_RESET;
        end else begin
            wr_prev_r <= wr_lvl;
            if (wr_go && addr_i == 2'h3 && data_i[7]) begin
                seen_r <= 1'b1;
                cw_r <= data_i;
            end
        end
    end
    AST_CW_READ: assert property (!cs_n_i && !rd_n_i && addr_i == 2'h3 |-> !data_oe_o)
        else $error("control word read drove the bus");
    AST_RESET_IN: assert property (!seen_r |-> (pa_oe_o | pb_oe_o | pc_oe_o) == 8'h00)
        else $error("pin driven before any mode word");
    AST_A_DIR: assert property (!cw_r[6] |-> pa_oe_o == {8{!cw_r[4]}})
        else $error("port A direction differs from mode word");
    AST_B_DIR: assert property (pb_oe_o == {8{!cw_r[1]}})
        else $error("port B direction differs from mode word");
    AST_M2_DIR: assert property (cw_r[6] |-> pa_oe_o == {8{!pc_i[6]}})
        else $error("bidirectional port A drive not tied to acknowledge");
    AST_WR_A: assert property (wr_go && addr_i == 2'h0 && !cw_r[6] && !cw_r[4]
        |=> pa_o == $past(data_i)) else $error("port A latch missed a write");
    AST_OBF_A: assert property (wr_go && addr_i == 2'h0 && out_a |=> !pc_o[7])
        else $error("output full not shown after write");
    AST_IBF_A: assert property ($fell(pc_i[4]) && in_a |=> pc_o[5])
        else $error("input full not shown after strobe");
    COV_M2_ACK: cover property (cw_r[6] && !pc_i[6]);
    COV_STB_A: cover property ($fell(pc_i[4]) && in_a);
    COV_WR_OUT: cover property (wr_go && addr_i == 2'h0 && out_a);
endmodule
bind ppp_top ppp_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i),
    .data_i(data_i), .data_oe_o(data_oe_o), .pa_o(pa_o), .pa_oe_o(pa_oe_o),
    .pb_oe_o(pb_oe_o), .pc_i(pc_i), .pc_o(pc_o), .pc_oe_o(pc_oe_o));
`default_nettype wire

// ==== verification/ppp_periph.sv ====
// Peripheral model: strobes bytes in, acknowledges bytes out, resolves pins.
`default_nettype none
module ppp_periph (
    input wire logic clk_sys_i,
    input wire logic [7:0] pa_d_i,
    input wire logic [7:0] pa_e_i,
    input wire logic [7:0] pb_d_i,
    input wire logic [7:0] pb_e_i,
    input wire logic [7:0] pc_d_i,
    input wire logic [7:0] pc_e_i,
    output logic [7:0] pa_o,
    output logic [7:0] pb_o,
    output logic [7:0] pc_o,
    output logic [7:0] got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] a_r = 8'h5A;
    logic [7:0] b_r = 8'hC3;
    logic [7:0] c_r = 8'hFF;
    // A bit the device drives shows its level, any other this side's.
    assign pa_o = (pa_e_i & pa_d_i) | (~pa_e_i & a_r);
    assign pb_o = (pb_e_i & pb_d_i) | (~pb_e_i & b_r);
    assign pc_o = (pc_e_i & pc_d_i) | (~pc_e_i & c_r);
    // The byte on port A is taken while its acknowledge is low.
    always @(posedge clk_sys_i) begin
        if (!c_r[6]) begin
            got_o <= pa_o;
        end
    end
    // Strobe low for one clock; the released bus then shows the inverse byte.
    task automatic strobe(input int bit_n, input logic [7:0] d, input logic to_b);
        @(posedge clk_sys_i);
        if (to_b) b_r <= d;
        else a_r <= d;
        c_r[bit_n] <= 1'b0;
        @(posedge clk_sys_i);
        c_r[bit_n] <= 1'b1;
        @(posedge clk_sys_i);
        if (to_b) b_r <= ~d;
        else a_r <= ~d;
        #1;
    endtask
    // Acknowledge low for n clocks, so both prompt and slow takers are seen.
    task automatic ack(input int bit_n, input int n);
        @(posedge clk_sys_i);
        c_r[bit_n] <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        c_r[bit_n] <= 1'b1;
        @(posedge clk_sys_i);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verification/programmable_parallel_port_test.sv ====
// Self-checking bench for the programmable parallel port.
`default_nettype none
module programmable_parallel_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cs_n_i = 1'b1;
    logic rd_n_i = 1'b1;
    logic wr_n_i = 1'b1;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] data_i = 8'h00;
    logic [7:0] pin_a, pin_b, pin_c, dev_a, dev_b, dev_c, oe_a, oe_b, oe_c;
    logic [7:0] dout, got, rv, cx;
    logic doe;
    int error_cnt = 0;
    int checks = 0;
    ppp_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
        .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i),
        .data_o(dout), .data_oe_o(doe), .pa_i(pin_a), .pa_o(dev_a), .pa_oe_o(oe_a),
        .pb_i(pin_b), .pb_o(dev_b), .pb_oe_o(oe_b), .pc_i(pin_c), .pc_o(dev_c),
        .pc_oe_o(oe_c));
    ppp_periph per (.clk_sys_i(clk_sys_i), .pa_d_i(dev_a), .pa_e_i(oe_a),
        .pb_d_i(dev_b), .pb_e_i(oe_b), .pc_d_i(dev_c), .pc_e_i(oe_c),
        .pa_o(pin_a), .pb_o(pin_b), .pc_o(pin_c), .got_o(got));
    // Free-running 50 MHz system clock.
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // Compare with case equality so that unknowns never match.
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // One bus write; the strobe is released for two clocks before the next.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        cs_n_i <= 1'b0;
        wr_n_i <= 1'b0;
        addr_i <= a;
        data_i <= d;
        @(posedge clk_sys_i);
        cs_n_i <= 1'b1;
        wr_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
    endtask
    // Two-cycle read, then one clock so that its clearing side effects land.
    task automatic rc(input logic [1:0] a, input logic [7:0] e, input string what);
        logic oe_seen;
        @(posedge clk_sys_i);
        cs_n_i <= 1'b0;
        rd_n_i <= 1'b0;
        addr_i <= a;
        @(posedge clk_sys_i);
        #1 oe_seen = doe;
        @(posedge clk_sys_i);
        cs_n_i <= 1'b1;
        rd_n_i <= 1'b1;
        #1 rv = dout;
        @(posedge clk_sys_i);
        #1 chk(what, e, rv);
        chk("read enable", {7'h00, a != 2'h3}, {7'h00, oe_seen});
    endtask
    task automatic tend(input string name);
        $display("test %s finished", name);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        $display("CHECK FAILED run time expected end seen hang");
        test_done();
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1 chk("oe after reset", 8'h00, oe_a | oe_b | oe_c);
        rc(2'h0, 8'h5A, "live a");
        rc(2'h1, 8'hC3, "live b");
        rc(2'h3, 8'h00, "control read");
        tend("reset");
        wr(2'h3, 8'h80);
        wr(2'h0, 8'h3C);
        wr(2'h1, 8'hA5);
        wr(2'h2, 8'h96);
        chk("pins a", 8'h3C, pin_a);
        chk("pins b", 8'hA5, pin_b);
        chk("pins c", 8'h96, pin_c);
        rc(2'h0, 8'h3C, "latch a");
        cx = 8'h96;
        for (int i = 0; i < 16; i++) begin
            cx[i % 8] = 1'(i < 8);
            wr(2'h3, {4'h0, 3'(i % 8), 1'(i < 8)});
            chk("bit set reset", cx, pin_c);
        end
        wr(2'h3, 8'h88);
        chk("c halves", 8'h0F, oe_c);
        wr(2'h3, 8'h81);
        chk("c halves", 8'hF0, oe_c);
        tend("mode 0");
        wr(2'h3, 8'hB6);
        wr(2'h3, 8'h09);
        wr(2'h3, 8'h05);
        wr(2'h3, 8'h0F);
        per.strobe(4, 8'h71, 1'b0);
        per.strobe(2, 8'h4E, 1'b1);
        chk("input flags", 8'hBF, pin_c);
        rc(2'h2, 8'hBF, "status");
        rc(2'h0, 8'h71, "strobed a");
        rc(2'h1, 8'h4E, "strobed b");
        chk("flags after read", 8'h94, pin_c);
        tend("mode 1 in");
        wr(2'h3, 8'hA4);
        wr(2'h3, 8'h0D);
        wr(2'h3, 8'h05);
        wr(2'h0, 8'hE7);
        wr(2'h1, 8'h1D);
        chk("out pins a", 8'hE7, pin_a);
        chk("output full", 8'h00, pin_c & 8'h8B);
        per.ack(6, 1);
        per.ack(2, 3);
        chk("ack flags", 8'h8B, pin_c & 8'h8B);
        chk("taken a", 8'hE7, got);
        wr(2'h0, 8'h11);
        chk("write clears", 8'h00, pin_c & 8'h88);
        tend("mode 1 out");
        wr(2'h3, 8'hC0);
        wr(2'h3, 8'h0D);
        wr(2'h3, 8'h09);
        wr(2'h0, 8'h2B);
        chk("bus floats", 8'h00, oe_a);
        chk("pending out", 8'h00, pin_c & 8'h88);
        per.ack(6, 3);
        chk("taken a", 8'h2B, got);
        chk("sent flags", 8'h88, pin_c & 8'h88);
        per.strobe(4, 8'h66, 1'b0);
        chk("received", 8'h20, pin_c & 8'h20);
        rc(2'h0, 8'h66, "latched in");
        wr(2'h1, 8'h33);
        chk("pins b", 8'h33, pin_b);
        tend("mode 2");
        test_done();
    end
endmodule
`default_nettype wire
